// ### bench/cfu_pmem.sv
// program memory model handing decoded instructions to the unit
`timescale 1ns/1ns
`default_nettype none
module cfu_pmem (
  input  wire logic               clock,
  input  wire logic               req_ready,
  output var  logic               req_valid,
  output var  cfu_pkg::cfu_req_t  req,
  output var  cfu_pkg::cfu_opnd_t opnd,
  output var  logic               hung
);
  // ****************************************
  // instruction hand-over
  // ****************************************
  initial begin
    req_valid = 1'b0;
    {req, opnd} = '0;
    hung = 1'b0;
  end
  // hold word and operands until taken; afterwards show the inverse so stale data is never used
  task automatic issue(input cfu_pkg::cfu_req_t r, input cfu_pkg::cfu_opnd_t o);
    int n;
    @(negedge clock);
    {req, opnd} = {r, o};
    req_valid = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 16; n++)
      @(negedge clock);
    hung = (n == 16);
    @(posedge clock);
    @(negedge clock);
    {req, opnd} = ~{r, o};
    req_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### bench/cfu_unit_chk.sv
// port assertions for the control-flow instruction unit
`timescale 1ns/1ns
`default_nettype none
module cfu_unit_chk (
  input wire logic                     clock,
  input wire logic                     rst,
  input wire logic                     clk_en,
  input wire logic                     req_valid,
  input wire logic                     req_ready,
  input wire cfu_pkg::cfu_req_t        req,
  input wire cfu_pkg::cfu_opnd_t       opnd,
  input wire logic                     done,
  input wire logic [cfu_pkg::PC_W-1:0] pc_next,
  input wire logic                     pc_jump,
  input wire logic [7:0]               flags_out,
  input wire logic                     flags_we
);
  // ****************************************
  // timing, targets and flags of finished work
  // ****************************************
  // a request counts only at an edge where the unit is idle and enabled
  wire logic acc = req_valid && req_ready;
  wire logic cmp = req.op inside {cfu_pkg::CFU_COMPARE_REGISTERS,
                   cfu_pkg::CFU_COMPARE_WITH_CARRY, cfu_pkg::CFU_COMPARE_IMMEDIATE};
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ind_call_target: assert property (
    acc && req.op == cfu_pkg::CFU_INDIRECT_CALL |=> pc_next == {6'h00, $past(opnd.z)}
    && !done ##1 done) else $error("indirect call target or timing wrong");
  a_ext_call_time: assert property (
    acc && req.op == cfu_pkg::CFU_EXTENDED_INDIRECT_CALL |=> pc_next == {$past(opnd.ext_upper),
    $past(opnd.z)} && !done ##1 !done ##1 done) else $error("extended call wrong");
  a_equal_skip: assert property (
    acc && req.op == cfu_pkg::CFU_COMPARE_SKIP_EQUAL && opnd.rd == opnd.rr && !req.next_two
    |=> pc_next == $past(req.pc) + 22'h000002 && !done ##1 done) else $error("equal skip wrong");
  a_compare_flags: assert property (
    acc && cmp |=> flags_we && done && pc_next == $past(req.pc) + 22'h000001)
    else $error("compare did not write flags in one cycle");
  a_flags_kept: assert property (
    acc && !cmp |=> !flags_we && flags_out == $past(opnd.flags)) else $error("flags altered");
  a_io_skip_long: assert property (
    acc && req.op == cfu_pkg::CFU_SKIP_IO_BIT_SET && opnd.io[req.bit_sel] && req.next_two
    |=> !done [*3] ##1 done) else $error("io skip over two words not four cycles");
  a_signed_less: assert property (
    acc && req.op == cfu_pkg::CFU_BRANCH_SIGNED_LT |=> pc_jump == ($past(opnd.flags[2]) ^
    $past(opnd.flags[3]))) else $error("signed less-than decision wrong");
  a_irq_not_taken: assert property (
    acc && req.op == cfu_pkg::CFU_BRANCH_IRQ_ENABLED && !opnd.flags[7] |=> done && !pc_jump)
    else $error("interrupt branch not one cycle untaken");
endmodule
bind cfu_unit cfu_unit_chk i_chk (.clock(clock), .rst(rst), .clk_en(clk_en),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .opnd(opnd), .done(done),
  .pc_next(pc_next), .pc_jump(pc_jump), .flags_out(flags_out), .flags_we(flags_we));
`default_nettype wire

// ### bench/cfu_unit_tb.sv
// self-checking bench for the control-flow instruction unit
`timescale 1ns/1ns
`default_nettype none
module cfu_unit_tb;
  // ****************************************
  // clock, design, program memory model and scenarios
  // ****************************************
  logic                     clock = 1'b0;
  logic                     rst = 1'b1;
  logic                     clk_en = 1'b1;
  logic                     req_valid, req_ready, done, pc_jump, flags_we, hung;
  logic [cfu_pkg::PC_W-1:0] pc_next;
  logic [7:0]               flags_out;
  cfu_pkg::cfu_req_t        req, r;
  cfu_pkg::cfu_opnd_t       opnd, o;
  int                       mismatches = 0;
  int                       check_count = 0;
  // core clock, 8 ns period
  always #4 clock = ~clock;
  cfu_unit i_dut (.clock(clock), .rst(rst), .clk_en(clk_en), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .opnd(opnd), .done(done), .pc_next(pc_next),
    .pc_jump(pc_jump), .flags_out(flags_out), .flags_we(flags_we));
  cfu_pmem i_pmem (.clock(clock), .req_ready(req_ready), .req_valid(req_valid), .req(req),
    .opnd(opnd), .hung(hung));
  // one comparison; four-state so an unknown never matches
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hand over r and o, then judge cycle count, next pc, jump flag and flag byte
  task automatic exec(input int n_exp, input logic [21:0] pc_exp, input logic jmp,
                      input logic [7:0] s_exp);
    int n;
    i_pmem.issue(r, o);
    for (n = 1; done !== 1'b1 && n < 8; n++)
      @(negedge clock);
    chk("cycles", n, n_exp);
    chk("pc_next", pc_next, pc_exp);
    chk("pc_jump", pc_jump, jmp);
    chk("flags_out", flags_out, s_exp);
    chk("flags_we", flags_we, r.op inside {cfu_pkg::CFU_COMPARE_REGISTERS,
        cfu_pkg::CFU_COMPARE_WITH_CARRY, cfu_pkg::CFU_COMPARE_IMMEDIATE});
    if (hung === 1'b1 || n == 8) begin
      mismatches++;
      end_of_test();
    end
  endtask
  // reset with the clock enable low: refused while frozen, cleared outputs after release
  task automatic t_reset();
    @(negedge clock);
    {rst, clk_en} = 2'b10;
    @(negedge clock);
    chk("ready frozen", req_ready, 1'b0);
    {rst, clk_en} = 2'b01;
    #1;
    chk("ready", req_ready, 1'b1);
    chk("done", done, 1'b0);
    chk("pc_next", pc_next, cfu_pkg::PC_RST);
    chk("pc_jump", pc_jump, 1'b0);
    chk("flags_out", flags_out, cfu_pkg::FLAGS_RST);
    chk("flags_we", flags_we, 1'b0);
  endtask
  // both indirect calls: upper bits cleared, or taken from the extension register
  task automatic t_calls();
    r = '0;
    r.op = cfu_pkg::CFU_INDIRECT_CALL;
    r.pc = 22'h2ABCDE;
    o = {24'h000000, 16'hBEEF, 6'h2A, 8'h5A};
    exec(2, 22'h00BEEF, 1'b1, 8'h5A);
    r.op = cfu_pkg::CFU_EXTENDED_INDIRECT_CALL;
    exec(3, 22'h2ABEEF, 1'b1, 8'h5A);
  endtask
  // the compares; the last two keep zero only when it was already set
  task automatic t_compare();
    cfu_pkg::cfu_op_t ops [5] = '{cfu_pkg::CFU_COMPARE_REGISTERS, cfu_pkg::CFU_COMPARE_IMMEDIATE,
                                  cfu_pkg::CFU_COMPARE_WITH_CARRY, cfu_pkg::CFU_COMPARE_WITH_CARRY,
                                  cfu_pkg::CFU_COMPARE_WITH_CARRY};
    logic [31:0] v [5] = '{32'h1020C0D5, 32'h80010038, 32'h05050335, 32'h06050302, 32'h06050100};
    for (int i = 0; i < 5; i++) begin
      r = '0;
      r.op = ops[i];
      r.imm = v[i][23:16];
      o = {v[i][31:16], 30'h0, v[i][15:8]};
      // the immediate form must ignore the second register
      if (i == 1) o.rr = 8'h80;
      exec(1, 22'h000001, 1'b0, v[i][7:0]);
    end
  endtask
  // bit skips of both polarities and sources, one- and two-word successors, then equal skip
  task automatic t_skips();
    logic       skip, nt;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        r = '0;
        r.op = cfu_pkg::cfu_op_t'(int'(cfu_pkg::CFU_SKIP_REG_BIT_CLEAR) + k);
        r.bit_sel = 3'(k + 2 * j + 1);
        r.pc = 22'h000200;
        nt = (k >= 2) ~^ (j == 1);
        r.next_two = nt;
        skip = (j == k % 2);
        v = j ? (8'h01 << r.bit_sel) : ~(8'h01 << r.bit_sel);
        o = {k >= 2 ? {~v, ~v, v} : {v, v, ~v}, 22'h0, 8'hA5};
        exec((k >= 2 ? 2 : 1) + (skip ? (nt ? 2 : 1) : 0),
             22'h000200 + (skip ? (nt ? 22'h3 : 22'h2) : 22'h1), skip, 8'hA5);
      end
    end
    r.op = cfu_pkg::CFU_COMPARE_SKIP_EQUAL;
    {o.rd, o.rr} = 16'h5A5B;
    exec(1, 22'h000201, 1'b0, 8'hA5);
    {o.rr, r.next_two} = {8'h5A, 1'b0};
    exec(2, 22'h000202, 1'b1, 8'hA5);
  endtask
  // every flag branch against four flag bytes, backward and forward offsets
  task automatic t_branches();
    int         fb [10] = '{0, 1, 0, 0, 2, 0, 5, 6, 3, 7};
    logic [9:0] inv = 10'h028;
    logic [7:0] s;
    logic       t;
    logic [21:0] pe;
    for (int i = 0; i < 20; i++) begin
      for (int q = 0; q < 4; q++) begin
        s = 8'(8'h55 * q);
        r = '0;
        o = '0;
        r.op = cfu_pkg::cfu_op_t'(int'(cfu_pkg::CFU_BRANCH_FLAG_SET) + i);
        r.bit_sel = 3'(i + q);
        r.offset = i % 2 ? 7'h40 : 7'h3F;
        r.pc = 22'h001000;
        o.flags = s;
        t = (i / 2 == 0 ? s[r.bit_sel] : i / 2 == 5 ? s[2] ^ s[3] : s[fb[i / 2]]) ^ i[0]
            ^ inv[i / 2];
        pe = r.pc + 22'h1 + (t ? {{15{r.offset[6]}}, r.offset} : 22'h0);
        exec(t ? 2 : 1, pe, t, s);
      end
    end
  endtask
  // reset held for ten cycles, then a reset check, the scenarios and a second reset check at the end
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_calls();
    t_compare();
    t_skips();
    t_branches();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire

// ### rtl/cfu_pkg.sv
// constants and types for the control-flow instruction unit
package cfu_pkg;

  // ***************************************************
  // widths
  // ***************************************************
  localparam int PC_W  = 22;
  localparam int Z_W   = 16;
  localparam int EXT_W = 6;
  localparam int CYC_W = 3;

  // ***************************************************
  // status flag register bit positions
  // ***************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int SIGN_BIT = 7;
  localparam int HALF_BIT = 3;

  // ***************************************************
  // reset values, program counter steps, cycle counts
  // ***************************************************
  localparam logic [PC_W-1:0]  PC_RST   = 22'h000000;
  localparam logic [7:0]       FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0]  STEP_ONE = 22'h000001;
  localparam logic [PC_W-1:0]  STEP_SK1 = 22'h000002;
  localparam logic [PC_W-1:0]  STEP_SK2 = 22'h000003;
  localparam logic [CYC_W-1:0] CYC_ONE    = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO    = 3'h2;
  localparam logic [CYC_W-1:0] CYC_THREE  = 3'h3;
  localparam logic [CYC_W-1:0] CYC_IND_CALL = 3'h2;
  localparam logic [CYC_W-1:0] CYC_EXT_CALL = 3'h3;

  // ***************************************************
  // operations handled by this unit
  // ***************************************************
  typedef enum logic [4:0] {
    CFU_INDIRECT_CALL, CFU_EXTENDED_INDIRECT_CALL,
    CFU_COMPARE_SKIP_EQUAL, CFU_COMPARE_REGISTERS,
    CFU_COMPARE_WITH_CARRY, CFU_COMPARE_IMMEDIATE,
    CFU_SKIP_REG_BIT_CLEAR, CFU_SKIP_REG_BIT_SET,
    CFU_SKIP_IO_BIT_CLEAR, CFU_SKIP_IO_BIT_SET,
    CFU_BRANCH_FLAG_SET, CFU_BRANCH_FLAG_CLEAR,
    CFU_BRANCH_EQUAL, CFU_BRANCH_NOT_EQUAL,
    CFU_BRANCH_CARRY_SET, CFU_BRANCH_CARRY_CLEAR,
    CFU_BRANCH_SAME_OR_HIGHER, CFU_BRANCH_LOWER,
    CFU_BRANCH_MINUS, CFU_BRANCH_PLUS,
    CFU_BRANCH_SIGNED_GE, CFU_BRANCH_SIGNED_LT,
    CFU_BRANCH_HALF_CARRY_SET, CFU_BRANCH_HALF_CARRY_CLEAR,
    CFU_BRANCH_TRANSFER_BIT_SET, CFU_BRANCH_TRANSFER_BIT_CLEAR,
    CFU_BRANCH_OVERFLOW_SET, CFU_BRANCH_OVERFLOW_CLEAR,
    CFU_BRANCH_IRQ_ENABLED, CFU_BRANCH_IRQ_DISABLED
  } cfu_op_t;

  // decoded instruction as handed over from program memory fetch
  typedef struct packed {
    cfu_op_t         op;
    logic [2:0]      bit_sel;   // flag or register/io bit number
    logic [6:0]      offset;    // signed relative branch offset
    logic [7:0]      imm;       // immediate compare operand
    logic [PC_W-1:0] pc;        // address of this instruction
    logic            next_two;  // following instruction is two words
  } cfu_req_t;

  // operands read from register file, io space and flag register
  typedef struct packed {
    logic [7:0]       rd;
    logic [7:0]       rr;
    logic [7:0]       io;
    logic [Z_W-1:0]   z;
    logic [EXT_W-1:0] ext_upper;
    logic [7:0]       flags;
  } cfu_opnd_t;

  typedef enum logic [1:0] {
    CFU_ST_IDLE = 2'b01,
    CFU_ST_RUN  = 2'b10
  } cfu_state_t;

endpackage

// ### rtl/cfu_unit.sv
// control-flow and compare execution unit of an 8-bit core
`timescale 1ns/1ns
`default_nettype none

module cfu_unit (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire cfu_pkg::cfu_req_t req,
  input  wire cfu_pkg::cfu_opnd_t opnd,
  output logic                   done,
  output logic [cfu_pkg::PC_W-1:0] pc_next,
  output logic                   pc_jump,
  output logic [7:0]             flags_out,
  output logic                   flags_we
);

  // ***************************************************
  // hand-over timing
  // ***************************************************
  // a request is taken at a rising edge with req_valid and req_ready high;
  // pc_next, pc_jump and flags_out change at that same edge and then hold
  // until the next acceptance, so they can be read at any later cycle.
  // done pulses for one cycle once the instruction's cycle count has run:
  //   compare 1, branch 1 untaken or 2 taken, register skip 1/2/3,
  //   io skip 2/3/4, indirect call 2, extended indirect call 3.
  // req_ready is low while a multi-cycle instruction is still counting,
  // and low while clk_en is low, so the source simply holds its request.
  // the return address and stack traffic of the calls live elsewhere.

  // ***************************************************
  // helper functions
  // ***************************************************

  // subtraction flags shared by the three compare forms
  function automatic logic [7:0] cmp_flags(
    input logic [7:0] d,
    input logic [7:0] r,
    input logic       cin,
    input logic [7:0] s,
    input logic       chain_z
  );
    logic [7:0] res;
    logic [7:0] f;
    res = d - r - {7'h00, cin};
    f = s;
    // borrows out of bit 3 and bit 7 give half-carry and carry
    f[cfu_pkg::FLAG_H] = (~d[cfu_pkg::HALF_BIT] & r[cfu_pkg::HALF_BIT])
                       | (r[cfu_pkg::HALF_BIT] & res[cfu_pkg::HALF_BIT])
                       | (res[cfu_pkg::HALF_BIT] & ~d[cfu_pkg::HALF_BIT]);
    f[cfu_pkg::FLAG_C] = (~d[cfu_pkg::SIGN_BIT] & r[cfu_pkg::SIGN_BIT])
                       | (r[cfu_pkg::SIGN_BIT] & res[cfu_pkg::SIGN_BIT])
                       | (res[cfu_pkg::SIGN_BIT] & ~d[cfu_pkg::SIGN_BIT]);
    // overflow when the operands differ in sign and the result follows r
    f[cfu_pkg::FLAG_V] = (d[cfu_pkg::SIGN_BIT] & ~r[cfu_pkg::SIGN_BIT]
                          & ~res[cfu_pkg::SIGN_BIT])
                       | (~d[cfu_pkg::SIGN_BIT] & r[cfu_pkg::SIGN_BIT]
                          & res[cfu_pkg::SIGN_BIT]);
    f[cfu_pkg::FLAG_N] = res[cfu_pkg::SIGN_BIT];
    f[cfu_pkg::FLAG_S] = f[cfu_pkg::FLAG_N] ^ f[cfu_pkg::FLAG_V];
    // the carry form only keeps zero if it was already set
    f[cfu_pkg::FLAG_Z] = (res == 8'h00) & (~chain_z | s[cfu_pkg::FLAG_Z]);
    return f;
  endfunction

  // branch condition for every conditional branch form
  function automatic logic branch_taken(
    input cfu_pkg::cfu_op_t op,
    input logic [7:0]       s,
    input logic [2:0]       sel
  );
    logic t;
    t = 1'b0;
    case (op)
      cfu_pkg::CFU_BRANCH_FLAG_SET:   t = s[sel];
      cfu_pkg::CFU_BRANCH_FLAG_CLEAR: t = ~s[sel];
      cfu_pkg::CFU_BRANCH_EQUAL:      t = s[cfu_pkg::FLAG_Z];
      cfu_pkg::CFU_BRANCH_NOT_EQUAL:  t = ~s[cfu_pkg::FLAG_Z];
      cfu_pkg::CFU_BRANCH_CARRY_SET,
      cfu_pkg::CFU_BRANCH_LOWER:      t = s[cfu_pkg::FLAG_C];
      cfu_pkg::CFU_BRANCH_CARRY_CLEAR,
      cfu_pkg::CFU_BRANCH_SAME_OR_HIGHER: t = ~s[cfu_pkg::FLAG_C];
      cfu_pkg::CFU_BRANCH_MINUS:      t = s[cfu_pkg::FLAG_N];
      cfu_pkg::CFU_BRANCH_PLUS:       t = ~s[cfu_pkg::FLAG_N];
      // signed tests use n xor v, not the stored sign flag
      cfu_pkg::CFU_BRANCH_SIGNED_GE:
        t = ~(s[cfu_pkg::FLAG_N] ^ s[cfu_pkg::FLAG_V]);
      cfu_pkg::CFU_BRANCH_SIGNED_LT:
        t = s[cfu_pkg::FLAG_N] ^ s[cfu_pkg::FLAG_V];
      cfu_pkg::CFU_BRANCH_HALF_CARRY_SET:   t = s[cfu_pkg::FLAG_H];
      cfu_pkg::CFU_BRANCH_HALF_CARRY_CLEAR: t = ~s[cfu_pkg::FLAG_H];
      cfu_pkg::CFU_BRANCH_TRANSFER_BIT_SET:   t = s[cfu_pkg::FLAG_T];
      cfu_pkg::CFU_BRANCH_TRANSFER_BIT_CLEAR: t = ~s[cfu_pkg::FLAG_T];
      cfu_pkg::CFU_BRANCH_OVERFLOW_SET:   t = s[cfu_pkg::FLAG_V];
      cfu_pkg::CFU_BRANCH_OVERFLOW_CLEAR: t = ~s[cfu_pkg::FLAG_V];
      cfu_pkg::CFU_BRANCH_IRQ_ENABLED:  t = s[cfu_pkg::FLAG_I];
      cfu_pkg::CFU_BRANCH_IRQ_DISABLED: t = ~s[cfu_pkg::FLAG_I];
      // compares, skips and calls never branch here
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // ***************************************************
  // state
  // ***************************************************
  // remain counts the cycles still owed after the accepting edge
  cfu_pkg::cfu_state_t         state;
  logic [cfu_pkg::CYC_W-1:0]   remain;

  logic [cfu_pkg::PC_W-1:0]    next_pc;
  logic                        next_jump;
  logic [7:0]                  next_flags;
  logic                        next_we;
  logic [cfu_pkg::CYC_W-1:0]   next_cyc;

  logic                        accept;
  logic [cfu_pkg::PC_W-1:0]    pc_seq;
  logic [cfu_pkg::PC_W-1:0]    pc_skip;
  logic [cfu_pkg::PC_W-1:0]    pc_rel;
  logic [cfu_pkg::CYC_W-1:0]   skip_cyc;

  // new work only while idle; a frozen clock enable stalls the source
  assign req_ready = (state == cfu_pkg::CFU_ST_IDLE) & clk_en;
  assign accept    = req_valid & req_ready;

  // ***************************************************
  // target address arithmetic
  // ***************************************************

  // skip distance depends on the length of the skipped instruction
  assign pc_seq  = req.pc + cfu_pkg::STEP_ONE;
  assign pc_skip = req.pc + (req.next_two ? cfu_pkg::STEP_SK2
                                          : cfu_pkg::STEP_SK1);
  // offset is sign-extended; the sum wraps at the top of program space
  assign pc_rel  = req.pc + {{(cfu_pkg::PC_W-7){req.offset[6]}}, req.offset}
                 + cfu_pkg::STEP_ONE;
  assign skip_cyc = req.next_two ? cfu_pkg::CYC_THREE
                                 : cfu_pkg::CYC_TWO;

  // ***************************************************
  // per-instruction result
  // ***************************************************
  always_comb begin
    next_pc   = pc_seq;
    next_jump = 1'b0;
    next_flags = opnd.flags;
    next_we   = 1'b0;
    next_cyc  = cfu_pkg::CYC_ONE;
    case (req.op)
      // calls: target from the pointer, no flags touched
      cfu_pkg::CFU_INDIRECT_CALL: begin
        next_pc   = {{cfu_pkg::EXT_W{1'b0}}, opnd.z};
        next_jump = 1'b1;
        next_cyc  = cfu_pkg::CYC_IND_CALL;
      end
      cfu_pkg::CFU_EXTENDED_INDIRECT_CALL: begin
        next_pc   = {opnd.ext_upper, opnd.z};
        next_jump = 1'b1;
        next_cyc  = cfu_pkg::CYC_EXT_CALL;
      end
      // equal compare leaves the flags alone and may skip
      cfu_pkg::CFU_COMPARE_SKIP_EQUAL: begin
        if (opnd.rd == opnd.rr) begin
          next_pc   = pc_skip;
          next_jump = 1'b1;
          next_cyc  = skip_cyc;
        end
      end
      // compares: the difference itself is dropped, only flags kept
      cfu_pkg::CFU_COMPARE_REGISTERS: begin
        next_flags = cmp_flags(opnd.rd, opnd.rr, 1'b0,
                               opnd.flags, 1'b0);
        next_we   = 1'b1;
      end
      cfu_pkg::CFU_COMPARE_WITH_CARRY: begin
        next_flags = cmp_flags(opnd.rd, opnd.rr,
                               opnd.flags[cfu_pkg::FLAG_C],
                               opnd.flags, 1'b1);
        next_we   = 1'b1;
      end
      cfu_pkg::CFU_COMPARE_IMMEDIATE: begin
        next_flags = cmp_flags(opnd.rd, req.imm, 1'b0,
                               opnd.flags, 1'b0);
        next_we   = 1'b1;
      end
      cfu_pkg::CFU_SKIP_REG_BIT_CLEAR,
      cfu_pkg::CFU_SKIP_REG_BIT_SET: begin
        // polarity of the test follows the variant
        if (opnd.rr[req.bit_sel] ==
            (req.op == cfu_pkg::CFU_SKIP_REG_BIT_SET)) begin
          next_pc   = pc_skip;
          next_jump = 1'b1;
          next_cyc  = skip_cyc;
        end
      end
      cfu_pkg::CFU_SKIP_IO_BIT_CLEAR,
      cfu_pkg::CFU_SKIP_IO_BIT_SET: begin
        // io read costs one cycle more than a register test
        next_cyc = cfu_pkg::CYC_TWO;
        if (opnd.io[req.bit_sel] ==
            (req.op == cfu_pkg::CFU_SKIP_IO_BIT_SET)) begin
          next_pc   = pc_skip;
          next_jump = 1'b1;
          next_cyc  = skip_cyc + cfu_pkg::CYC_ONE;
        end
      end
      default: begin
        // every remaining operation is a conditional branch
        if (branch_taken(req.op, opnd.flags, req.bit_sel)) begin
          next_pc   = pc_rel;
          next_jump = 1'b1;
          next_cyc  = cfu_pkg::CYC_TWO;
        end
      end
    endcase
  end

  // ***************************************************
  // result registers
  // ***************************************************

  // results are captured at acceptance and held until the next one
  // a low clk_en keeps every result register as it is
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pc_next   <= cfu_pkg::PC_RST;
      pc_jump   <= 1'b0;
      flags_out <= cfu_pkg::FLAGS_RST;
    end else if (clk_en && accept) begin
      pc_next   <= next_pc;
      pc_jump   <= next_jump;
      flags_out <= next_flags;   // flags pass unchanged unless compared
    end
  end

  // flag write strobe: one pulse, only for the compare forms
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_we <= 1'b0;
    end else if (clk_en) begin
      flags_we <= accept & next_we;
    end
  end

  // ***************************************************
  // cycle sequencing
  // ***************************************************

  // done pulses once, the given number of cycles after acceptance
  // single-cycle work never leaves idle, so it runs back to back
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state  <= cfu_pkg::CFU_ST_IDLE;
      remain <= cfu_pkg::CYC_ONE;
      done   <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (state)
        cfu_pkg::CFU_ST_IDLE: begin
          if (accept) begin
            if (next_cyc == cfu_pkg::CYC_ONE) begin
              done <= 1'b1;
            end else begin
              remain <= next_cyc - cfu_pkg::CYC_ONE;
              state  <= cfu_pkg::CFU_ST_RUN;
            end
          end
        end
        cfu_pkg::CFU_ST_RUN: begin
          remain <= remain - cfu_pkg::CYC_ONE;
          if (remain == cfu_pkg::CYC_ONE) begin
            done  <= 1'b1;
            state <= cfu_pkg::CFU_ST_IDLE;
          end
        end
        default: begin
          state <= cfu_pkg::CFU_ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire
